// >>> core/swcoe_regs.vh
// Control register layout and timing for the switch control block.
// Included by the control block; definitions only.
`ifndef SWCOE_REGS_VH
`define SWCOE_REGS_VH

`define SWCOE_CTRL_RESET      16'h0000
`define SWCOE_SOFT_RESET_BIT  15
`define SWCOE_PASSTHRU_BIT    14
`define SWCOE_IND_POL_BIT     13
`define SWCOE_ALL_IND_BIT     12
`define SWCOE_PAT_RESTART_BIT 11
`define SWCOE_ERR_CLR_BIT     10
`define SWCOE_ERR_START_BIT   9
`define SWCOE_WHOLE_FILL_BIT  8
`define SWCOE_PATTERN_HI      7
`define SWCOE_PATTERN_LO      5
`define SWCOE_FILL_BEGIN_BIT  4
`define SWCOE_LOW_CLEAR_BIT   3
`define SWCOE_STANDBY_BIT     2
`define SWCOE_MEMSEL_HI       1
`define SWCOE_MEMSEL_LO       0
`define SWCOE_MODE_HIZ        3'h7
`define SWCOE_MEMSEL_CML      2'h0
`define SWCOE_MEMSEL_CMH      2'h1
`define SWCOE_MEMSEL_DM       2'h2
// Minimum soft reset hold time in ns, and cycles at 20 ns (rounded up)
`define SWCOE_SRST_NS         20
`define SWCOE_CLK_NS          20
`define SWCOE_SRST_CYC        ((`SWCOE_SRST_NS + `SWCOE_CLK_NS - 1) / `SWCOE_CLK_NS)

`endif

// >>> core/swcoe_ctrl.v
// Switch control register, fill sequencer and transmit drive decision.
// Assumes a simple synchronous host write/read port and a per-slot mode feed from
// the switching datapath; memory accesses are made by that datapath on our strobes.
//
// What this block does
// - Group output-enable bit 0 forces that group's outputs to high impedance.
// - Drive-enable pin and standby both 0 put all outputs in high impedance.
// - Drive-enable pin or standby at 1 lets outputs drive normally.
// - Control bit 15 drives soft_reset_out, holds transmit drivers off and blocks memory writes; other control bits keep their values.
// - Control bit 14 shorts receive streams straight to transmit.
// - Control bit 13 sets indication pin polarity.
// - Indication mode is chosen per transmit group by rate settings.
// - Control bit 12 turns every transmit pin into an indication pin.
// - Control bit 11 high holds the pattern transmitter in its initial state.
// - Rising edge of control bit 10 clears the error count.
// - Rising edge of control bit 9 starts the error test.
// - Control bit 8 fills whole memory, else start/end addresses bound it.
// - Fill writes pattern bits 7-5 into high word bits 2-0.
// - Rising edge of control bit 4 starts block programming.
// - Device clears the fill-begin bit when filling finishes.
// - Writing zero to fill-begin during a fill aborts it.
// - Control bit 3 set makes the fill zero low word bits 14-0.
// - Bits 1-0 select low, high or data memory for host access.
// - Channel mode 1-1-1 drives that slot to high impedance.
// - During soft reset only writes to the soft reset bit are accepted.
// - Completion of the fill also zeroes the pattern bits.
`include "swcoe_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module swcoe_ctrl #(
    parameter GROUPS = 8
) (
    // Clock and reset
    input  wire              mclk,
    input  wire              rst,
    // Host control register port
    input  wire              ctrl_wr,
    input  wire [15:0]       ctrl_wdata,
    output reg  [15:0]       ctrl_rdata,
    output reg               mem_wr_allow,
    output reg  [1:0]        host_memory_select,
    output reg               reserved_select,
    // Pins and per-group settings
    input  wire              drive_enable_pin,
    input  wire [GROUPS-1:0] group_output_enable,
    input  wire [GROUPS-1:0] group_indication_mode,
    input  wire [2:0]        channel_mode_field,
    input  wire [2:0]        slot_group,
    // Transmit drive decisions
    output reg  [GROUPS-1:0] tx_drive_en,
    output reg  [GROUPS-1:0] enable_indication_pin,
    output reg               rx_tx_passthrough,
    output reg               all_pins_indication,
    output reg               soft_reset_out,
    // Error test controls
    output reg               pattern_restart,
    output reg               error_count_clear,
    output reg               error_test_start,
    // Fill sequencer link
    output reg               fill_active,
    output reg               whole_memory_fill,
    output reg  [2:0]        fill_pattern,
    output reg               low_word_clear_on_fill,
    output reg               fill_abort,
    input  wire              fill_done
);

    localparam ST_IDLE = 1'b0;
    localparam ST_FILL = 1'b1;

    reg  [15:0] ctrl_reg;
    reg  [15:0] ctrl_next;
    reg         fill_state_reg;
    reg         fill_state_next;
    reg         clr_prev_reg;
    reg         start_prev_reg;
    reg         fill_abort_next;
    reg  [1:0]  srst_cnt_reg;
    wire        soft_reset = ctrl_reg[`SWCOE_SOFT_RESET_BIT];
    wire        fill_bit   = ctrl_reg[`SWCOE_FILL_BEGIN_BIT];
    wire        standby    = ctrl_reg[`SWCOE_STANDBY_BIT];
    wire        pol        = ctrl_reg[`SWCOE_IND_POL_BIT];

    always @* begin
        ctrl_next       = ctrl_reg;
        fill_state_next = fill_state_reg;
        fill_abort_next = 1'b0;
        if (ctrl_wr && soft_reset) begin
            ctrl_next[`SWCOE_SOFT_RESET_BIT] = ctrl_wdata[`SWCOE_SOFT_RESET_BIT];
        end else if (ctrl_wr) begin
            ctrl_next = ctrl_wdata;
        end
        case (fill_state_reg)
            ST_IDLE: begin
                if (!fill_bit && ctrl_next[`SWCOE_FILL_BEGIN_BIT] && !soft_reset) begin
                    fill_state_next = ST_FILL;
                end else begin
                    ctrl_next[`SWCOE_FILL_BEGIN_BIT] = ctrl_next[`SWCOE_FILL_BEGIN_BIT]
                                                       & fill_bit;
                end
            end
            ST_FILL: begin
                if (ctrl_wr && !ctrl_wdata[`SWCOE_FILL_BEGIN_BIT]) begin
                    fill_state_next = ST_IDLE;
                    fill_abort_next = 1'b1;
                end else if (fill_done) begin
                    fill_state_next = ST_IDLE;
                    ctrl_next[`SWCOE_FILL_BEGIN_BIT] = 1'b0;
                    ctrl_next[`SWCOE_PATTERN_HI:`SWCOE_PATTERN_LO] = 3'h0;
                end else begin
                    ctrl_next[`SWCOE_FILL_BEGIN_BIT] = 1'b1;
                end
            end
            default: fill_state_next = ST_IDLE;
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            ctrl_reg       <= `SWCOE_CTRL_RESET;
            fill_state_reg <= ST_IDLE;
            clr_prev_reg   <= 1'b0;
            start_prev_reg <= 1'b0;
            srst_cnt_reg   <= 2'h0;
        end else begin
            ctrl_reg       <= ctrl_next;
            fill_state_reg <= fill_state_next;
            clr_prev_reg   <= ctrl_reg[`SWCOE_ERR_CLR_BIT];
            start_prev_reg <= ctrl_reg[`SWCOE_ERR_START_BIT];
            if (soft_reset && srst_cnt_reg != 2'h3) begin
                srst_cnt_reg <= srst_cnt_reg + 2'h1;
            end else if (!soft_reset) begin
                srst_cnt_reg <= 2'h0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < GROUPS; g = g + 1) begin : grp
            wire on = group_output_enable[g]
                      && (drive_enable_pin || standby)
                      && !(slot_group == g && channel_mode_field == `SWCOE_MODE_HIZ);
            always @(posedge mclk) begin
                if (rst) begin
                    tx_drive_en[g]           <= 1'b0;
                    enable_indication_pin[g] <= 1'b0;
                end else begin
                    // group enable gates all; all pins become indication
                    tx_drive_en[g] <= on && !soft_reset
                                      && !ctrl_reg[`SWCOE_ALL_IND_BIT];
                    enable_indication_pin[g] <= (group_indication_mode[g]
                                                 || ctrl_reg[`SWCOE_ALL_IND_BIT])
                                                ? ~((on && !soft_reset) ^ pol) : 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (rst) begin
            ctrl_rdata             <= 16'h0000;
            mem_wr_allow           <= 1'b0;
            host_memory_select     <= 2'h0;
            reserved_select        <= 1'b0;
            rx_tx_passthrough      <= 1'b0;
            all_pins_indication    <= 1'b0;
            soft_reset_out         <= 1'b0;
            pattern_restart        <= 1'b0;
            error_count_clear      <= 1'b0;
            error_test_start       <= 1'b0;
            fill_active            <= 1'b0;
            whole_memory_fill      <= 1'b0;
            fill_pattern           <= 3'h0;
            low_word_clear_on_fill <= 1'b0;
            fill_abort             <= 1'b0;
        end else begin
            ctrl_rdata   <= ctrl_next;
            // memory writes blocked in soft reset
            mem_wr_allow <= !ctrl_next[`SWCOE_SOFT_RESET_BIT];
            host_memory_select <= ctrl_next[`SWCOE_MEMSEL_HI:`SWCOE_MEMSEL_LO];
            reserved_select    <= &ctrl_next[`SWCOE_MEMSEL_HI:`SWCOE_MEMSEL_LO];
            rx_tx_passthrough   <= ctrl_next[`SWCOE_PASSTHRU_BIT];
            all_pins_indication <= ctrl_next[`SWCOE_ALL_IND_BIT];
            soft_reset_out      <= ctrl_next[`SWCOE_SOFT_RESET_BIT];
            pattern_restart     <= ctrl_reg[`SWCOE_PAT_RESTART_BIT];
            error_count_clear   <= ctrl_reg[`SWCOE_ERR_CLR_BIT] && !clr_prev_reg;
            error_test_start    <= ctrl_reg[`SWCOE_ERR_START_BIT] && !start_prev_reg;
            fill_active         <= fill_state_next == ST_FILL;
            whole_memory_fill   <= ctrl_next[`SWCOE_WHOLE_FILL_BIT];
            // pattern to high word bits 2-0
            fill_pattern        <= ctrl_next[`SWCOE_PATTERN_HI:`SWCOE_PATTERN_LO];
            low_word_clear_on_fill <= ctrl_next[`SWCOE_LOW_CLEAR_BIT];
            fill_abort          <= fill_abort_next;
        end
    end

endmodule

`default_nettype wire

// >>> testbench/swcoe_ctrl_asserts.sv
// Checker for the switch control block: drive decision, register and fill.
// Bound to swcoe_ctrl; sees only its ports, single clock domain.
`timescale 1ns/100ps
`default_nettype none
module swcoe_ctrl_asserts #(
    parameter GROUPS = 8
) (
    // Clock, reset and host port
    input wire logic              mclk, rst, ctrl_wr, fill_done, drive_enable_pin,
    input wire logic [15:0]       ctrl_wdata, ctrl_rdata,
    // Drive decision
    input wire logic [GROUPS-1:0] group_output_enable, tx_drive_en,
    input wire logic [2:0]        channel_mode_field, slot_group,
    // Status and strobes
    input wire logic              soft_reset_out, error_count_clear, error_test_start,
    input wire logic              fill_active, fill_abort
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Drive outputs lag inputs by one cycle, so skip the edge right after reset
    chk_group_off_hiz: assert property (!$past(rst) |-> (tx_drive_en & ~$past(group_output_enable)) == 0)
        else $error("driver on while group enable low");
    chk_all_pins_hiz: assert property (!$past(rst) && !$past(drive_enable_pin) && !$past(ctrl_rdata[2]) |-> tx_drive_en == 0)
        else $error("driver on with pin and standby low");
    chk_drive_normal: assert property (!$past(rst) && $past(group_output_enable[0] && (drive_enable_pin || ctrl_rdata[2]) && !ctrl_rdata[15] && !ctrl_rdata[12] && slot_group != 3'h0) |-> tx_drive_en[0])
        else $error("group 0 not driving");
    chk_slot_hiz: assert property (!$past(rst) && $past(channel_mode_field) == 3'h7 |-> !tx_drive_en[$past(slot_group)])
        else $error("slot in high impedance mode still driven");
    chk_soft_reset_quiet: assert property (ctrl_rdata[15] |-> soft_reset_out ##1 tx_drive_en == 0)
        else $error("soft reset not holding outputs");
    chk_soft_reset_lock: assert property (ctrl_wr && ctrl_rdata[15] && !fill_done |=> ctrl_rdata[14:0] == $past(ctrl_rdata[14:0]))
        else $error("write accepted during soft reset");
    chk_write_take: assert property (ctrl_wr && !ctrl_rdata[15] && !fill_done |=> ctrl_rdata[15:5] == $past(ctrl_wdata[15:5]) && ctrl_rdata[3:0] == $past(ctrl_wdata[3:0]))
        else $error("control write not taken");
    chk_clear_pulse: assert property ($rose(ctrl_rdata[10]) |=> error_count_clear ##1 !error_count_clear)
        else $error("error clear pulse wrong");
    chk_start_pulse: assert property (error_test_start |-> $past(ctrl_rdata[9]) && !$past(ctrl_rdata[9], 2))
        else $error("error test start without rising bit");
    chk_fill_begin: assert property (ctrl_wr && ctrl_wdata[4] && !ctrl_rdata[4] && !ctrl_rdata[15] |=> fill_active)
        else $error("fill did not start");
    chk_fill_finish: assert property (fill_active && fill_done && !ctrl_wr |=> !fill_active && ctrl_rdata[7:4] == 4'h0)
        else $error("fill completion not cleared");
    chk_fill_abort: assert property (fill_active && ctrl_wr && !ctrl_wdata[4] && !ctrl_rdata[15] |=> fill_abort && !fill_active)
        else $error("fill abort missing");
endmodule
bind swcoe_ctrl swcoe_ctrl_asserts #(.GROUPS(GROUPS)) swcoe_ctrl_asserts_inst (.*);
`default_nettype wire

// >>> testbench/swcoe_ctrl_tb_top.sv
// Self-checking bench for the switch control block.
// Drives every input of swcoe_ctrl directly; the checker is bound separately.
`timescale 1ns/100ps
`default_nettype none
module swcoe_ctrl_tb_top;
    logic        mclk, rst, ctrl_wr, drive_enable_pin, fill_done;
    logic [15:0] ctrl_wdata, d;
    logic [7:0]  group_output_enable, group_indication_mode;
    logic [2:0]  channel_mode_field, slot_group;
    wire  [15:0] ctrl_rdata;
    wire  [7:0]  tx_drive_en, enable_indication_pin;
    wire  [2:0]  fill_pattern;
    wire  [1:0]  host_memory_select;
    wire         mem_wr_allow, reserved_select, rx_tx_passthrough, all_pins_indication;
    wire         soft_reset_out, pattern_restart, error_count_clear, error_test_start;
    wire         fill_active, whole_memory_fill, low_word_clear_on_fill, fill_abort;
    int          num_errors = 0;
    int          total_checks = 0;
    swcoe_ctrl #(.GROUPS(8)) swcoe_ctrl_inst (.*);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Leaves a gap cycle so the strobe is never lowered and raised in one step
    task automatic wr(input logic [15:0] v);
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1);
    endtask
    function automatic logic [7:0] exp_tx(input logic [15:0] c);
        exp_tx = group_output_enable & {8{(drive_enable_pin | c[2]) & !c[15] & !c[12]}};
        if (channel_mode_field == 3'h7)
            exp_tx[slot_group] = 1'b0;
    endfunction
    function automatic logic [7:0] exp_ind(input logic [15:0] c);
        exp_ind = (group_indication_mode | {8{c[12]}})
                  & ~(exp_tx(c & 16'hefff) ^ {8{c[13]}});
    endfunction
    task automatic results;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        results();
    end
    initial begin
        {rst, ctrl_wr, drive_enable_pin, fill_done} = 4'h8;
        ctrl_wdata = 16'h0000;
        {group_output_enable, group_indication_mode} = 16'h0000;
        {channel_mode_field, slot_group} = 6'h00;
        void'($urandom(17));
        tick(6);
        rst = 1'b0;
        chk("ctrl reset", 16'h0000, ctrl_rdata);
        for (int i = 0; i < 40; i++) begin
            d = 16'($urandom) & 16'h7fef;
            wr(d);
            chk("ctrl", d, ctrl_rdata);
            chk("memsel", {d[1:0], d[1:0] == 2'h3}, {host_memory_select, reserved_select});
            chk("copies", {d[14], d[12], d[8], d[7:5], d[3]}, {rx_tx_passthrough,
                all_pins_indication, whole_memory_fill, fill_pattern, low_word_clear_on_fill});
            chk("wr allow", 1'b1, mem_wr_allow);
            // random group settings stand in for companion rates
            {group_output_enable, group_indication_mode, drive_enable_pin, channel_mode_field,
                slot_group} = 23'($urandom);
            if (i % 4 == 0)
                channel_mode_field = 3'h7;
            tick(1);
            chk("tx drive", exp_tx(d), tx_drive_en);
            chk("restart", d[11], pattern_restart);
            chk("indication", exp_ind(d), enable_indication_pin);
        end
        wr(16'h0000);
        wr(16'h0600);
        chk("pulses", 2'h3, {error_count_clear, error_test_start});
        tick(1);
        chk("pulses end", 2'h0, {error_count_clear, error_test_start});
        wr(16'h0600);
        chk("pulses held", 2'h0, {error_count_clear, error_test_start});
        wr(16'h01f8);
        chk("fill start", 1'b1, fill_active);
        fill_done = 1'b1;
        tick(1);
        fill_done = 1'b0;
        tick(1);
        chk("fill end", {16'h0108, 1'b0}, {ctrl_rdata, fill_active});
        wr(16'h0010);
        ctrl_wr = 1'b1;
        ctrl_wdata = 16'h0000;
        tick(1);
        ctrl_wr = 1'b0;
        chk("abort", 2'h2, {fill_abort, fill_active});
        tick(1);
        wr(16'h8000);
        chk("soft reset", 2'h2, {soft_reset_out, mem_wr_allow});
        wr(16'h8003);
        chk("srs lock", 16'h8000, ctrl_rdata);
        {group_output_enable, drive_enable_pin, channel_mode_field} = 12'hff8;
        tick(1);
        chk("srs drive", 8'h00, tx_drive_en);
        wr(16'h0000);
        wr(16'h0004);
        drive_enable_pin = 1'b0;
        tick(1);
        chk("standby", 8'hff, tx_drive_en);
        results();
    end
endmodule
`default_nettype wire
